// ---- src/sram_controller.sv ----
// Synchronous controller that drives an asynchronous 1M x 4 static memory through its pins
`timescale 1ns/1ps
module sram_controller (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire sram_ctrl_pkg::request_t reqIn,
  output logic reqReady,
  output logic rspValid,
  output logic [sram_ctrl_pkg::DataWidth-1:0] rspData,
  output logic [sram_ctrl_pkg::AddrWidth-1:0] wordAddress,
  output sram_ctrl_pkg::strobes_t strobes,
  output logic [sram_ctrl_pkg::DataWidth-1:0] dataPinsOut,
  output logic [sram_ctrl_pkg::DataWidth-1:0] dataPinsOeN,
  input wire logic [sram_ctrl_pkg::DataWidth-1:0] dataPinsIn
);
  import sram_ctrl_pkg::*;

  ctrlState_t state_q;
  ctrlState_t state_d;
  logic [AddrWidth-1:0] addr_q;
  logic [AddrWidth-1:0] addr_d;
  logic [DataWidth-1:0] wdata_q;
  logic [DataWidth-1:0] wdata_d;
  logic driveN_q;
  logic driveN_d;
  strobes_t strobes_q;
  strobes_t strobes_d;
  logic ready_q;
  logic ready_d;
  logic rspValid_q;
  logic rspValid_d;
  logic [DataWidth-1:0] rspData_q;
  logic [DataWidth-1:0] rspData_d;
  logic timerLoad;
  logic [CntWidth-1:0] timerValue;
  logic timerDone;

  interval_timer u_interval_timer (
    .clk(clk),
    .rst_n(rst_n),
    .load(timerLoad),
    .loadValue(timerValue),
    .done(timerDone)
  );

  // Sequencing group: state, timer and the pin values that the strobes qualify
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    driveN_d = driveN_q;
    strobes_d = strobes_q;
    timerLoad = 1'b0;
    timerValue = CntZero;
    case (state_q)
      StIdle: begin
        if (reqValid && ready_q) begin
          // Address goes out with chip select in the same edge, never later
          addr_d = reqIn.wordAddress;
          strobes_d.chipSelectN = 1'b0;
          timerLoad = 1'b1;
          if (reqIn.write) begin
            // Gate stays high and strobe falls with select, so the memory never drives
            wdata_d = reqIn.data;
            strobes_d.outputGateN = 1'b1;
            strobes_d.writeStrobeN = 1'b0;
            timerValue = TurnCycles;
            state_d = StWriteSetup;
          end else begin
            strobes_d.outputGateN = 1'b0;
            timerValue = ReadCycles;
            state_d = StRead;
          end
        end
      end
      StRead: begin
        // Strobes end only after the full access time has passed
        if (timerDone) begin
          strobes_d.chipSelectN = 1'b1;
          strobes_d.outputGateN = 1'b1;
          timerLoad = 1'b1;
          timerValue = TurnCycles;
          state_d = StRecover;
        end
      end
      StWriteSetup: begin
        // Pins stay released until the memory output is certainly off
        if (timerDone) begin
          driveN_d = 1'b0;
          timerLoad = 1'b1;
          timerValue = WritePulseCycles;
          state_d = StWritePulse;
        end
      end
      StWritePulse: begin
        // Address, select and data all held through the pulse end
        if (timerDone) begin
          strobes_d.writeStrobeN = 1'b1;
          strobes_d.chipSelectN = 1'b1;
          timerLoad = 1'b1;
          timerValue = TurnCycles;
          state_d = StRecover;
        end
      end
      StRecover: begin
        // Data released one edge after the strobes rise; zero hold is allowed
        driveN_d = 1'b1;
        // Gap lets memory outputs float and keeps cycles spaced
        if (timerDone) begin
          state_d = StIdle;
        end
      end
      default: begin
        state_d = StIdle;
        strobes_d = '{chipSelectN: 1'b1, writeStrobeN: 1'b1, outputGateN: 1'b1};
        driveN_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= StIdle;
      addr_q <= '0;
      wdata_q <= '0;
      driveN_q <= 1'b1;
      // Deselected from reset: memory in standby, pins floating
      strobes_q <= '{chipSelectN: 1'b1, writeStrobeN: 1'b1, outputGateN: 1'b1};
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      driveN_q <= driveN_d;
      strobes_q <= strobes_d;
    end
  end

  // Ready drops on the edge that takes a request and rises after the recovery gap
  always_comb begin
    ready_d = 1'b0;
    case (state_q)
      StIdle: begin
        ready_d = !(reqValid && ready_q);
      end
      StRecover: begin
        ready_d = timerDone;
      end
      default: begin
        ready_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
    end
  end

  // Pins are sampled once, when the read access time has run out
  always_comb begin
    rspValid_d = 1'b0;
    rspData_d = rspData_q;
    if (state_q == StRead && timerDone) begin
      rspValid_d = 1'b1;
      rspData_d = dataPinsIn;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rspValid_q <= 1'b0;
      rspData_q <= '0;
    end else begin
      rspValid_q <= rspValid_d;
      rspData_q <= rspData_d;
    end
  end

  // One enable and one data flop per pin, so each can sit next to its pad
  for (genvar i = 0; i < DataWidth; i++) begin : g_pin
    logic oeN_q;
    logic oeN_d;
    logic out_q;
    logic out_d;
    always_comb begin
      oeN_d = driveN_d;
      out_d = wdata_d[i];
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        oeN_q <= 1'b1;
        out_q <= 1'b0;
      end else begin
        oeN_q <= oeN_d;
        out_q <= out_d;
      end
    end
    assign dataPinsOeN[i] = oeN_q;
    assign dataPinsOut[i] = out_q;
  end

  assign reqReady = ready_q;
  assign rspValid = rspValid_q;
  assign rspData = rspData_q;
  assign wordAddress = addr_q;
  assign strobes = strobes_q;
endmodule

// ---- common/sram_ctrl_pkg.sv ----
// Package: pin groups, timing constants and states for the static memory controller
package sram_ctrl_pkg;

  localparam int AddrWidth = 20;
  localparam int DataWidth = 4;
  localparam int ClkPeriodNs = 10;

  // Speed grade timing, fastest grade, in ns
  localparam int CycleTimeNs = 10;
  localparam int AccessTimeNs = 10;
  localparam int WritePulseNs = 8;
  localparam int WriteToHighZNs = 6;
  localparam int DataSetupNs = 6;
  localparam int OutputOffNs = 5;
  localparam int OutputAfterWriteNs = 3;

  localparam int CntWidth = 4;

  // Least times round up to whole cycles, never below one
  function automatic logic [CntWidth-1:0] cyclesUp(input int ns);
    int c;
    c = (ns + ClkPeriodNs - 1) / ClkPeriodNs;
    if (c < 1) begin
      c = 1;
    end
    return CntWidth'(c);
  endfunction

  localparam logic [CntWidth-1:0] ReadCycles = cyclesUp(AccessTimeNs + 1);
  localparam logic [CntWidth-1:0] CycleCycles = cyclesUp(CycleTimeNs);
  localparam logic [CntWidth-1:0] WritePulseCycles = cyclesUp(WriteToHighZNs + DataSetupNs);
  localparam logic [CntWidth-1:0] TurnCycles = cyclesUp(OutputOffNs);
  localparam logic [CntWidth-1:0] CntZero = '0;
  localparam logic [CntWidth-1:0] CntOne = CntWidth'(1);

  typedef enum logic [2:0] {
    StIdle = 3'b000,
    StRead = 3'b001,
    StWriteSetup = 3'b010,
    StWritePulse = 3'b011,
    StRecover = 3'b100
  } ctrlState_t;

  typedef struct packed {
    logic write;
    logic [AddrWidth-1:0] wordAddress;
    logic [DataWidth-1:0] data;
  } request_t;

  typedef struct packed {
    logic chipSelectN;
    logic writeStrobeN;
    logic outputGateN;
  } strobes_t;

endpackage

// ---- src/interval_timer.sv ----
// Down counter that times one pin interval in clock cycles
`timescale 1ns/1ps
module interval_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [sram_ctrl_pkg::CntWidth-1:0] loadValue,
  output logic done
);
  import sram_ctrl_pkg::*;

  logic [CntWidth-1:0] count_q;
  logic [CntWidth-1:0] count_d;

  always_comb begin
    count_d = count_q;
    if (load) begin
      count_d = loadValue;
    end else if (count_q != CntZero) begin
      count_d = count_q - CntOne;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= CntZero;
    end else begin
      count_q <= count_d;
    end
  end

  // Done while the count sits at one or zero, so the caller moves on the next edge.
  // Done must not look at load: the caller raises load from done, which would close a loop.
  assign done = (count_q <= CntOne);
endmodule

// ---- verification/sram_ctrl_checker.sv ----
// Pin timing assertions for the static memory controller
`timescale 1ns/1ps
module sram_ctrl_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic rspValid,
  input wire logic [sram_ctrl_pkg::AddrWidth-1:0] wordAddress,
  input wire sram_ctrl_pkg::strobes_t strobes,
  input wire logic [sram_ctrl_pkg::DataWidth-1:0] dataPinsOeN
);
  import sram_ctrl_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  gate_drive_a: assert property (!dataPinsOeN[0] |-> strobes.outputGateN)
    else $error("gate low while driving");
  gate_write_a: assert property (!strobes.writeStrobeN |-> strobes.outputGateN)
    else $error("gate low in write");
  write_pulse_a: assert property ($fell(strobes.writeStrobeN) |-> !strobes.chipSelectN[*3] ##1 strobes.writeStrobeN)
    else $error("write pulse length");
  data_setup_a: assert property ($rose(strobes.writeStrobeN) |-> $past(dataPinsOeN) == 4'h0)
    else $error("data not set up");
  addr_hold_a: assert property (!strobes.chipSelectN && $past(strobes.chipSelectN) == 1'b0 |-> $stable(wordAddress))
    else $error("address moved");
  read_time_a: assert property ($fell(strobes.outputGateN) |-> ##2 rspValid && strobes.chipSelectN)
    else $error("read answer timing");
  cycle_gap_a: assert property ($rose(strobes.chipSelectN) |-> strobes.chipSelectN[*2])
    else $error("cycles too close");
  busy_take_a: assert property (reqValid && reqReady |=> !reqReady)
    else $error("taken while busy");
endmodule
bind sram_controller sram_ctrl_checker u_sram_ctrl_checker (.clk, .rst_n, .reqValid, .reqReady, .rspValid,
  .wordAddress, .strobes, .dataPinsOeN);

// ---- verification/sram_model.sv ----
// Behavioural model of the 1M x 4 static memory on the controller's pins
`timescale 1ns/1ps
module sram_model #(
  parameter int AccNs = 9
) (
  input wire logic [sram_ctrl_pkg::AddrWidth-1:0] wordAddress,
  input wire sram_ctrl_pkg::strobes_t strobes,
  input wire logic [sram_ctrl_pkg::DataWidth-1:0] dataPinsOut,
  input wire logic [sram_ctrl_pkg::DataWidth-1:0] dataPinsOeN,
  output logic [sram_ctrl_pkg::DataWidth-1:0] dataPinsIn
);
  import sram_ctrl_pkg::*;
  logic [DataWidth-1:0] mem [logic [AddrWidth-1:0]]; // Sparse, no refresh
  logic [DataWidth-1:0] memOut = 4'h0;
  wire readOn = !strobes.chipSelectN && strobes.writeStrobeN && !strobes.outputGateN;
  wire writeOn = !strobes.chipSelectN && !strobes.writeStrobeN;
  // Answers late on purpose; old word stays until then
  always @(wordAddress or readOn) memOut <= #(AccNs) (mem.exists(wordAddress) ? mem[wordAddress] : 4'h0);
  always @(negedge writeOn) mem[wordAddress] = dataPinsIn;
  // Pins driven by neither side show the inverse, never a held value
  always_comb dataPinsIn = !dataPinsOeN[0] ? dataPinsOut : (readOn ? memOut : ~memOut);
endmodule

// ---- verification/sram_controller_tb_top.sv ----
// Self-checking bench for the static memory controller
`timescale 1ns/1ps
module sram_controller_tb_top;
  import sram_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reqValid = 1'b0;
  request_t reqIn = '0;
  logic reqReady, rspValid;
  logic [DataWidth-1:0] rspData, dataPinsOut, dataPinsOeN, dataPinsIn;
  logic [AddrWidth-1:0] wordAddress;
  strobes_t strobes;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [AddrWidth-1:0] corners [3] = '{20'h00000, 20'hFFFFF, 20'hA5A5A};

  sram_controller u_sram_controller (.clk, .rst_n, .reqValid, .reqIn, .reqReady, .rspValid, .rspData,
    .wordAddress, .strobes, .dataPinsOut, .dataPinsOeN, .dataPinsIn);
  sram_model u_sram_model (.wordAddress, .strobes, .dataPinsOut, .dataPinsOeN, .dataPinsIn);

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Leaves the request up so a caller can chain another without a gap
  task automatic put(input logic w, input logic [AddrWidth-1:0] a, input logic [DataWidth-1:0] d);
    int n;
    n = 0;
    reqIn <= '{write: w, wordAddress: a, data: d};
    reqValid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (reqReady !== 1'b1 && n < 20);
    chk("request taken", 8'h01, {7'h00, reqReady});
  endtask

  task automatic getWord(input logic [AddrWidth-1:0] a, input logic [DataWidth-1:0] exp);
    int n;
    n = 0;
    put(1'b0, a, 4'h0);
    reqValid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (rspValid !== 1'b1 && n < 10);
    chk("read answer", 8'h01, {7'h00, rspValid});
    chk("read latency", 8'(ReadCycles + 1), 8'(n));
    chk("read word", {4'h0, exp}, {4'h0, rspData});
  endtask

  task automatic test_idle();
    chk("idle pins", 8'h7F, {1'b0, strobes, dataPinsOeN});
    $display("test idle done");
  endtask

  task automatic test_corners();
    for (int i = 0; i < 3; i++) begin
      put(1'b1, corners[i], corners[i][3:0] ^ 4'h6);
      reqValid <= 1'b0;
      @(posedge clk);
    end
    for (int i = 0; i < 3; i++) begin
      getWord(corners[i], corners[i][3:0] ^ 4'h6);
    end
    $display("test corners done");
  endtask

  task automatic test_turnaround();
    put(1'b1, 20'h00000, 4'hF);
    getWord(20'h00000, 4'hF);
    chk("pins after read", 8'h7F, {1'b0, strobes, dataPinsOeN});
    $display("test turnaround done");
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    test_idle();
    test_corners();
    test_turnaround();
    end_of_test();
  end
endmodule
